// file: mgmt_ctrl_end.sv
// Purpose: controller end, turns register orders into sideband commands
// Assumes: software drives avalon-mm with waitrequest
// Notes: only controller-owned settings can be reached from here
`timescale 1ns/1ps
module mgmt_ctrl_end
   import mgmt_rx_pkg::*;
(
   input wire logic mclk, // 50 MHz clock
   input wire logic rst, // asynchronous reset
   mgmt_link_if.mc link, // sideband to filter
   input wire logic [3:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest // stall
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic pend;
      logic [7:0] addr;
      logic [31:0] data;
      logic fw;
      logic dec_used;
      logic [7:0] last_hits;
      logic [15:0] cnt;
   } mc_s;

   mc_s q, d;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      d = q;
      d.fw = 1'b0;
      // a data write stalls while an older command is still offered
      d.ack = (avs_read | avs_write) & ~q.ack & ~q.pend;
      if (q.pend && link.cmd_ready) d.pend = 1'b0;
      if (avs_read && !q.ack) begin
         case (avs_address)
            MCR_ADDR: d.rdata = {24'h0, q.addr};
            MCR_DATA: d.rdata = q.data;
            MCR_STATUS: d.rdata = {6'h0, link.sideband_smbus, q.pend, q.last_hits, q.cnt};
            default: d.rdata = 32'h0;
         endcase
      end
      if (avs_write && q.ack) begin
         case (avs_address)
            MCR_ADDR: d.addr = avs_writedata[7:0];
            // only controller settings exist in this map, so host unicast
            // entries, multicast table and promiscuous bits stay out of reach
            MCR_DATA: if (q.addr <= CMD_LAST) begin // [RULE_15] [RULE_17] [RULE_18]
               d.pend = 1'b1;
               d.data = avs_writedata; // [RULE_05]
               // selective filtering in use: keep everything bit clear [RULE_03]
               if (q.addr == CMD_MCTL && q.dec_used) d.data[MCTL_RX_ALL] = 1'b0;
               if (q.addr >= CMD_DEC && q.addr < CMD_DEC + 8'(DEC_N) && avs_writedata != 32'h0)
                  d.dec_used = 1'b1;
            end
            MCR_FWRST: if (avs_writedata[0]) begin
               d.fw = 1'b1; // [RULE_06]
               d.dec_used = 1'b0;
            end
            default: ;
         endcase
      end
      if (link.pkt_valid) begin
         d.last_hits = link.pkt_hits;
         d.cnt = q.cnt + 16'h1;
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
   assign avs_readdata = q.rdata;
   assign link.cmd_valid = q.pend;
   assign link.cmd_addr = q.addr;
   assign link.cmd_data = q.data;
   assign link.fw_reset = q.fw;
endmodule : mgmt_ctrl_end

// file: mgmt_link_if.sv
// Purpose: sideband link between the receive filter and the controller
// Assumes: both ends on mclk
// Notes: command channel is valid/ready, packet notice is a pulse
`timescale 1ns/1ps
interface mgmt_link_if;
   logic cmd_valid; // controller offers a setting write
   logic cmd_ready; // filter takes it
   logic [7:0] cmd_addr; // setting word index
   logic [31:0] cmd_data; // setting value
   logic fw_reset; // firmware reset pulse
   logic pkt_valid; // packet routed to controller, pulse
   logic [7:0] pkt_hits; // decision filters that matched
   logic [13:0] pkt_len; // packet length in bytes
   logic sideband_smbus; // two-wire bus sideband active
   modport dev (input cmd_valid, cmd_addr, cmd_data, fw_reset, output cmd_ready,
      pkt_valid, pkt_hits, pkt_len, sideband_smbus);
   modport mc (output cmd_valid, cmd_addr, cmd_data, fw_reset, input cmd_ready,
      pkt_valid, pkt_hits, pkt_len, sideband_smbus);
endinterface : mgmt_link_if

// file: mgmt_link_props.sv
// Purpose: concurrent checks on the sideband link between both ends
// Assumes: one clock, asynchronous active-high reset
// Notes: sees the link signals only, instantiated beside the interface
`timescale 1ns/1ps
module mgmt_link_props
   import mgmt_rx_pkg::*;
(
   input wire logic mclk, // clock
   input wire logic rst, // reset
   input wire logic cmd_valid, // command offered
   input wire logic cmd_ready, // command taken
   input wire logic [7:0] cmd_addr, // word index
   input wire logic [31:0] cmd_data, // word value
   input wire logic fw_reset, // firmware reset pulse
   input wire logic pkt_valid, // packet to controller
   input wire logic [7:0] pkt_hits, // decision hits
   input wire logic [13:0] pkt_len, // length
   input wire logic sideband_smbus // two-wire mode
);
   logic dec_sent_q; // a nonzero decision word went out
   // ************************************************************
   // helper state
   // ************************************************************
   // firmware reset wins over a decision word in the same cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dec_sent_q <= 1'b0;
      end else if (fw_reset) begin
         dec_sent_q <= 1'b0;
      end else if (cmd_valid && cmd_addr[7:3] == 5'h01 && cmd_data != 32'h0) begin
         dec_sent_q <= 1'b1;
      end
   end
   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_ready_high: assert property (cmd_ready)
      else $error("command ready low");
   a_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
      else $error("command valid held");
   a_cmd_in_map: assert property (cmd_valid |-> cmd_addr <= CMD_LAST)
      else $error("command outside map");
   a_all_forced_off: assert property (cmd_valid && cmd_addr == CMD_MCTL && dec_sent_q
      |-> !cmd_data[MCTL_RX_ALL]) else $error("everything bit sent while filtering");
   a_fw_pulse: assert property (fw_reset |=> !fw_reset)
      else $error("firmware reset held");
   a_smbus_held: assert property (!$fell(sideband_smbus))
      else $error("sideband mode dropped");
   a_smbus_at_start: assert property ($rose(sideband_smbus) |-> $past(rst, 2))
      else $error("sideband mode rose late");
   a_pkt_needs_smbus: assert property (pkt_valid |-> $past(sideband_smbus))
      else $error("packet routed outside two-wire mode");
endmodule : mgmt_link_props

// file: mgmt_rx_l2_filter.sv
// Purpose: layer-two pass stage and routing of received packets
// Assumes: rx_* fields are stable while rx_valid is high for one cycle
// Notes: one result per packet one cycle after rx_valid
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module mgmt_rx_l2_filter
   import mgmt_rx_pkg::*;
(
   input wire logic mclk, // 50 MHz clock
   input wire logic rst, // power-on reset
   mgmt_link_if.dev link, // sideband to controller
   input wire logic [4:0] avs_address, // driver byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   input wire logic strap_ncsi, // sideband select from nvm
   input wire logic nvm_we, // nvm reload write
   input wire logic [7:0] nvm_addr, // reload word index
   input wire logic [31:0] nvm_data, // reload value
   input wire logic rx_valid, // packet parsed, pulse
   input wire logic [47:0] rx_dst, // destination address
   input wire logic rx_vlan_present, // packet carries vlan tag
   input wire logic [11:0] rx_vlan_id, // vlan id
   input wire logic [31:0] rx_dst_ip, // ipv4 destination
   input wire logic rx_l4_hit, // port filter hit from parser
   input wire logic rx_frag, // fragmented packet
   input wire logic rx_crc_err, // crc or alignment error
   input wire logic [13:0] rx_len, // length in bytes
   output logic host_valid, // result pulse
   output logic host_accept // packet goes to host memory
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic strap_done;
      logic ncsi;
      logic [2:0] ctl;
      logic [3:0] uc_sel;
      logic [UC_HOST-1:0][48:0] uc;
      logic [MC_BITS-1:0] mc;
      logic [31:0] mctl;
      logic [7:0] m2h;
      logic [15:0] mval;
      logic [DEC_N-1:0][31:0] dec;
      logic [FILT_N-1:0][31:0] filt;
      logic res_valid;
      logic res_host;
      logic res_mgmt;
      logic [7:0] res_hits;
      logic [13:0] res_len;
      logic [15:0] cnt_mgmt;
      logic [15:0] cnt_host;
   } dev_s;

   dev_s q, d;
   logic [UC_ALL-1:0] uc_hit;
   logic [3:0] mac_hit;
   logic [3:0] ip_hit;
   logic [7:0] vlan_hit;
   logic [DEC_N-1:0] dec_hit;
   logic is_bc, is_mc, is_uc, mg_uc, vl_ok, ip_ok, l4_ok, size_err, err_ok, l2_pass;
   logic to_mgmt, cmd_we;
   logic [7:0] w_addr;
   logic [31:0] w_data;

   // ****************************************************************
   // per-entry matching
   // ****************************************************************
   genvar i;
   generate
      for (i = 0; i < UC_ALL; i = i + 1) begin : g_ent
         if (i < UC_HOST) begin : g_host
            assign uc_hit[i] = q.uc[i][48] && q.uc[i][47:0] == rx_dst;
         end else begin : g_mgmt
            assign uc_hit[i] = mac_hit[0]; // [RULE_16]
         end
         if (i < 4) begin : g_mac
            // validity bit or own bit enables the entry [RULE_12]
            assign mac_hit[i] = (q.filt[F_MAC+2*i+1][MAC_VALID] | q.mval[VAL_MAC+i])
               && {q.filt[F_MAC+2*i+1][15:0], q.filt[F_MAC+2*i]} == rx_dst;
            assign ip_hit[i] = (q.mctl[MCTL_IPV4_VALID] | q.mval[VAL_IP+i])
               && q.filt[F_IP+i] == rx_dst_ip; // [RULE_12]
         end
         if (i < DEC_N) begin : g_dec
            logic and_ok, or_en, or_hit;
            assign vlan_hit[i] = (q.filt[F_VLAN+i][VLAN_EN] | q.mval[VAL_VLAN+i])
               && rx_vlan_present && q.filt[F_VLAN+i][11:0] == rx_vlan_id;
            assign and_ok = !(q.dec[i][D_AND_UC] && !mg_uc) && !(q.dec[i][D_AND_BC] && !is_bc)
               && !(q.dec[i][D_AND_VLAN] && !vl_ok) && !(q.dec[i][D_AND_IP] && !ip_ok)
               && !(q.dec[i][D_AND_MC] && !is_mc);
            assign or_en = q.dec[i][D_OR_UC] | q.dec[i][D_OR_BC]
               | (|q.dec[i][D_OR_PORT_HI:D_OR_PORT_LO]);
            assign or_hit = (q.dec[i][D_OR_UC] & mg_uc) | (q.dec[i][D_OR_BC] & is_bc)
               | ((|q.dec[i][D_OR_PORT_HI:D_OR_PORT_LO]) & l4_ok);
            // an all-zero decision word is ignored
            assign dec_hit[i] = (|q.dec[i]) && and_ok && (!or_en || or_hit);
         end
      end
   endgenerate

   // ****************************************************************
   // packet classification
   // ****************************************************************
   assign is_bc = &rx_dst;
   assign is_mc = rx_dst[40] & ~is_bc;
   assign is_uc = ~rx_dst[40];
   assign mg_uc = is_uc & (|mac_hit);
   assign vl_ok = is_bc | (|vlan_hit); // [RULE_14]
   assign ip_ok = |ip_hit;
   assign l4_ok = rx_l4_hit & ~rx_frag; // no port parsing past ip [RULE_10]
   assign size_err = rx_len > LEN_MAX || rx_len < LEN_MIN;
   // only a pure size fault is tolerated, and only with store-bad set [RULE_11]
   assign err_ok = !rx_crc_err && (!size_err || q.ctl[CTL_SBP]);
   // five pass cases, multicast hash on twelve bits [RULE_13] [RULE_18] [RULE_19]
   assign l2_pass = (is_uc && (q.ctl[CTL_PROM_UC] || (|uc_hit)))
      || (is_mc && (q.ctl[CTL_PROM_MC] || q.mc[rx_dst[MC_HASH_LSB +: 12]])) || is_bc;
   // pass-through only on the two-wire bus sideband [RULE_21]
   assign to_mgmt = !q.ncsi && q.mctl[MCTL_RX_EN] && err_ok
      && (q.mctl[MCTL_RX_ALL] || (l2_pass && (|dec_hit))); // [RULE_01] [RULE_02] [RULE_09]

   // link command wins over nvm reload when both arrive
   assign cmd_we = link.cmd_valid | nvm_we; // [RULE_08]
   assign w_addr = link.cmd_valid ? link.cmd_addr : nvm_addr;
   assign w_data = link.cmd_valid ? link.cmd_data : nvm_data;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      d = q;
      d.ack = (avs_read | avs_write) & ~q.ack;
      // strap caught once after reset release [RULE_20]
      if (!q.strap_done) begin
         d.strap_done = 1'b1;
         d.ncsi = strap_ncsi;
      end
      if (avs_read && !q.ack) begin
         case (avs_address)
            DRV_CTRL: d.rdata = {29'h0, q.ctl};
            DRV_UC_SEL: d.rdata = {28'h0, q.uc_sel};
            DRV_UC_LO: d.rdata = q.uc_sel < 4'(UC_HOST) ? q.uc[q.uc_sel][31:0] : 32'h0;
            DRV_UC_HI: d.rdata = q.uc_sel < 4'(UC_HOST)
               ? {q.uc[q.uc_sel][48], 15'h0, q.uc[q.uc_sel][47:32]} : 32'h0;
            DRV_COUNT: d.rdata = {q.cnt_host, q.cnt_mgmt};
            DRV_STATUS: d.rdata = {21'h0, q.ncsi, q.res_mgmt, q.res_host, q.res_hits};
            default: d.rdata = 32'h0;
         endcase
      end
      if (avs_write && q.ack) begin
         case (avs_address)
            DRV_CTRL: d.ctl = avs_writedata[2:0]; // driver-only promiscuous bits [RULE_15]
            DRV_UC_SEL: d.uc_sel = avs_writedata[3:0];
            // entry fifteen is not writable by the driver [RULE_16]
            DRV_UC_LO: if (q.uc_sel < 4'(UC_HOST)) d.uc[q.uc_sel][31:0] = avs_writedata;
            DRV_UC_HI: if (q.uc_sel < 4'(UC_HOST))
               d.uc[q.uc_sel][48:32] = {avs_writedata[UC_VALID], avs_writedata[15:0]};
            DRV_MC_SET: d.mc[avs_writedata[11:0]] = avs_writedata[MC_SET_VAL]; // [RULE_18]
            default: ;
         endcase
      end
      // controller settings and filter contents [RULE_07]
      if (cmd_we) begin
         if (w_addr == CMD_MCTL) d.mctl = w_data;
         else if (w_addr == CMD_M2H) d.m2h = w_data[7:0];
         else if (w_addr == CMD_MVAL) d.mval = w_data[15:0];
         else if (w_addr >= CMD_DEC && w_addr < CMD_DEC + 8'(DEC_N))
            d.dec[3'(w_addr - CMD_DEC)] = w_data;
         else if (w_addr >= CMD_FILT && w_addr <= CMD_LAST)
            d.filt[6'(w_addr - CMD_FILT)] = w_data;
      end
      // firmware reset clears enables, mask and decisions only, filter contents stay [RULE_06]
      if (link.fw_reset) begin
         d.mctl = 32'h0;
         d.m2h = 8'h0;
         d.dec = '0;
      end
      d.res_valid = rx_valid;
      if (rx_valid) begin
         d.res_mgmt = to_mgmt;
         d.res_hits = dec_hit;
         d.res_len = rx_len;
         // host copy only with global enable and mask bit [RULE_04] [RULE_05]
         // rejected dedicated-address packets fall to the host path [RULE_22]
         d.res_host = to_mgmt ? (q.mctl[MCTL_M2H_EN] && (|(dec_hit & q.m2h)))
            : (l2_pass && err_ok);
         if (to_mgmt) d.cnt_mgmt = q.cnt_mgmt + 16'h1;
         if (d.res_host) d.cnt_host = q.cnt_host + 16'h1;
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // one wait state on every access
   assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
   assign avs_readdata = q.rdata;
   assign host_valid = q.res_valid;
   assign host_accept = q.res_valid & q.res_host;
   assign link.cmd_ready = 1'b1;
   assign link.pkt_valid = q.res_valid & q.res_mgmt;
   assign link.pkt_hits = q.res_hits;
   assign link.pkt_len = q.res_len;
   assign link.sideband_smbus = q.strap_done & ~q.ncsi; // [RULE_20]
endmodule : mgmt_rx_l2_filter

// file: mgmt_rx_pkg.sv
// Purpose: shared constants for the management receive filter and its partner
// Assumes: one 50 MHz clock, asynchronous active-high reset
// Notes: command addresses are word indices on the sideband link
// Operation
// (RULE_01) enable plus everything routes all packets
// (RULE_02) enable alone routes only decision-filter matches
// (RULE_03) controller keeps everything bit clear when filtering
// (RULE_04) management packets skip host memory by default
// (RULE_05) global enable plus mask bit copies to host
// (RULE_06) firmware reset clears enables, mask, decisions only
// (RULE_07) four macs, eight vlans, sixteen ports, four flex, four ip
// (RULE_08) settings may reload from nonvolatile memory
// (RULE_09) layer two check first, then manageability filters
// (RULE_10) fragments pass but nothing beyond ip parsed
// (RULE_11) layer two errors blocked except permitted size faults
// (RULE_12) filter enabled by validity bit or own bit
// (RULE_13) unicast, multicast, broadcast pass conditions
// (RULE_14) broadcast treats vlan check as matched
// (RULE_15) controller never touches promiscuous unicast
// (RULE_16) sixteen unicast entries, last one for management
// (RULE_17) controller programs entry fifteen only
// (RULE_18) multicast uses twelve address bits, driver owned
// (RULE_19) promiscuous multicast also feeds management path
// (RULE_20) exactly one sideband active, chosen by strap
// (RULE_21) pass-through only in two-wire bus mode
// (RULE_22) dedicated-address rejects go to the host
package mgmt_rx_pkg;
   // ****************************************************************
   // sizes
   // ****************************************************************
   localparam int UC_HOST = 15;
   localparam int UC_ALL = 16;
   localparam int MC_BITS = 4096;
   localparam int MC_HASH_LSB = 36;
   localparam int DEC_N = 8;
   localparam int FILT_N = 40;
   localparam logic [13:0] LEN_MAX = 14'h5F2;
   localparam logic [13:0] LEN_MIN = 14'h040;
   // ****************************************************************
   // sideband command map (word index)
   // ****************************************************************
   localparam logic [7:0] CMD_MCTL = 8'h00;
   localparam logic [7:0] CMD_M2H = 8'h01;
   localparam logic [7:0] CMD_MVAL = 8'h02;
   localparam logic [7:0] CMD_DEC = 8'h08;
   localparam logic [7:0] CMD_FILT = 8'h20;
   localparam logic [7:0] CMD_LAST = 8'h47;
   // filter word layout: mac pairs, vlans, ports, flex lengths, ip
   localparam int F_MAC = 0;
   localparam int F_VLAN = 8;
   localparam int F_PORT = 16;
   localparam int F_FLEX = 32;
   localparam int F_IP = 36;
   localparam int MAC_VALID = 31;
   localparam int VLAN_EN = 12;
   // control word bits
   localparam int MCTL_RX_EN = 0;
   localparam int MCTL_RX_ALL = 1;
   localparam int MCTL_M2H_EN = 2;
   localparam int MCTL_IPV4_VALID = 3;
   // validity word fields
   localparam int VAL_MAC = 0;
   localparam int VAL_VLAN = 4;
   localparam int VAL_IP = 12;
   // decision word bits
   localparam int D_AND_UC = 0;
   localparam int D_AND_BC = 1;
   localparam int D_AND_VLAN = 2;
   localparam int D_AND_IP = 3;
   localparam int D_OR_UC = 4;
   localparam int D_OR_BC = 5;
   localparam int D_AND_MC = 6;
   localparam int D_OR_PORT_LO = 12;
   localparam int D_OR_PORT_HI = 15;
   // ****************************************************************
   // avalon maps (byte address)
   // ****************************************************************
   localparam logic [4:0] DRV_CTRL = 5'h00;
   localparam logic [4:0] DRV_UC_SEL = 5'h04;
   localparam logic [4:0] DRV_UC_LO = 5'h08;
   localparam logic [4:0] DRV_UC_HI = 5'h0C;
   localparam logic [4:0] DRV_MC_SET = 5'h10;
   localparam logic [4:0] DRV_COUNT = 5'h14;
   localparam logic [4:0] DRV_STATUS = 5'h18;
   localparam int CTL_PROM_UC = 0;
   localparam int CTL_PROM_MC = 1;
   localparam int CTL_SBP = 2;
   localparam int UC_VALID = 31;
   localparam int MC_SET_VAL = 31;
   localparam logic [3:0] MCR_ADDR = 4'h0;
   localparam logic [3:0] MCR_DATA = 4'h4;
   localparam logic [3:0] MCR_FWRST = 4'h8;
   localparam logic [3:0] MCR_STATUS = 4'hC;
endpackage : mgmt_rx_pkg

// file: test_mgmt_rx_l2_filter.sv
// Purpose: self-checking bench for the filter end and the controller end
// Assumes: 50 MHz clock, reset held 16 cycles
// Notes: a packet result is judged at the edge after the one that takes it
`timescale 1ns/1ps
module test_mgmt_rx_l2_filter
   import mgmt_rx_pkg::*;
;
   localparam logic [47:0] UC_X = 48'h0200_0000_0C0C;
   localparam logic [47:0] MG = 48'h0200_0000_0B0F;
   localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
   localparam logic [47:0] ADR [6] = '{48'h0200_0000_0A01, UC_X, MG, 48'h0100_0000_0001,
      48'h0300_0000_0001, BC};
   localparam logic [5:0] HMAP [3] = '{6'h29, 6'h2F, 6'h39}; // host result per address
   logic mclk, rst, strap_ncsi, f_rd, f_wr, f_wait, c_rd, c_wr, c_wait;
   logic rx_valid, host_valid, host_accept, nvm_we;
   logic [7:0] nvm_addr;
   logic [4:0] f_addr;
   logic [3:0] c_addr, rx_f; // rx_f: vlan, crc error, fragment, port hit
   logic [31:0] f_wd, f_rdata, c_wd, c_rdata, q, nvm_data;
   logic [47:0] rx_dst;
   logic [13:0] rx_len;
   int n_errors, checks;
   // ************************************************************
   // both ends joined by the link
   // ************************************************************
   mgmt_link_if link ();
   mgmt_rx_l2_filter i_mgmt_rx_l2_filter (.mclk(mclk), .rst(rst), .link(link.dev),
      .avs_address(f_addr), .avs_read(f_rd), .avs_write(f_wr), .avs_writedata(f_wd),
      .avs_readdata(f_rdata), .avs_waitrequest(f_wait), .strap_ncsi(strap_ncsi),
      .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_data(nvm_data),
      .rx_valid(rx_valid), .rx_dst(rx_dst),
      .rx_vlan_present(rx_f[3]), .rx_vlan_id(12'h005), .rx_dst_ip(32'h0A00_0001),
      .rx_l4_hit(rx_f[0]), .rx_frag(rx_f[1]), .rx_crc_err(rx_f[2]), .rx_len(rx_len),
      .host_valid(host_valid), .host_accept(host_accept));
   mgmt_ctrl_end i_mgmt_ctrl_end (.mclk(mclk), .rst(rst), .link(link.mc), .avs_address(c_addr),
      .avs_read(c_rd), .avs_write(c_wr), .avs_writedata(c_wd), .avs_readdata(c_rdata),
      .avs_waitrequest(c_wait));
   mgmt_link_props i_mgmt_link_props (.mclk(mclk), .rst(rst), .cmd_valid(link.cmd_valid),
      .cmd_ready(link.cmd_ready), .cmd_addr(link.cmd_addr), .cmd_data(link.cmd_data),
      .fw_reset(link.fw_reset), .pkt_valid(link.pkt_valid), .pkt_hits(link.pkt_hits),
      .pkt_len(link.pkt_len), .sideband_smbus(link.sideband_smbus));
   // free-running clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   // one bus access on either end; held until waitrequest is seen low
   task automatic acc(input logic ctl, input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      c_addr <= a[3:0];
      f_addr <= a;
      c_wd <= d;
      f_wd <= d;
      {c_wr, c_rd, f_wr, f_rd} <= {ctl & wr, ctl & !wr, !ctl & wr, !ctl & !wr};
      do begin
         @(posedge mclk);
         n++;
      end while ((ctl ? c_wait : f_wait) !== 1'b0 && n < 40);
      if (n >= 40) begin
         n_errors++;
         finish_test();
      end
      q = ctl ? c_rdata : f_rdata;
      {c_wr, c_rd, f_wr, f_rd} <= 4'h0;
      @(posedge mclk);
   endtask : acc
   task automatic rd(input logic ctl, input logic [4:0] a, input logic [31:0] e, input string s);
      acc(ctl, 1'b0, a, 32'h0);
      chk(s, q, e);
   endtask : rd
   // a setting word goes out as index write then data write
   task automatic cmd(input logic [7:0] w, input logic [31:0] d);
      acc(1'b1, 1'b1, {1'b0, MCR_ADDR}, {24'h0, w});
      acc(1'b1, 1'b1, {1'b0, MCR_DATA}, d);
   endtask : cmd
   // e is {to host, to controller, hits}; hits only count while routed
   task automatic pkt(input logic [47:0] d, input logic [13:0] len, input logic [3:0] f,
         input logic [9:0] e);
      {rx_valid, rx_dst, rx_len, rx_f} <= {1'b1, d, len, f};
      @(posedge mclk);
      rx_valid <= 1'b0;
      @(posedge mclk);
      chk("packet", {21'h0, host_valid, host_accept, link.pkt_valid,
         link.pkt_hits & {8{link.pkt_valid}}}, {22'h1, e});
      if (e[8]) chk("length", {18'h0, link.pkt_len}, {18'h0, len});
   endtask : pkt
   task automatic rst_dut(input logic s);
      strap_ncsi <= s;
      rst <= 1'b1;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
   endtask : rst_dut
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      n_errors = 0;
      checks = 0;
      {f_rd, f_wr, c_rd, c_wr, rx_valid, f_addr, c_addr, f_wd, c_wd} = '0;
      {rx_dst, rx_len, rx_f, nvm_we, nvm_addr, nvm_data} = '0;
      rst_dut(1'b0);
      rd(0, DRV_CTRL, 32'h0, "drv ctrl");
      rd(0, DRV_STATUS, 32'h0, "drv status");
      rd(1, {1'b0, MCR_STATUS}, 32'h0200_0000, "ctl status");
      rd(0, 5'h1C, 32'h0, "unmapped");
      // driver entries; index 15 is refused from this side
      acc(0, 1, DRV_UC_SEL, 32'h3);
      acc(0, 1, DRV_UC_LO, ADR[0][31:0]);
      acc(0, 1, DRV_UC_HI, {16'h8000, ADR[0][47:32]});
      acc(0, 1, DRV_UC_SEL, 32'hF);
      acc(0, 1, DRV_UC_LO, MG[31:0]);
      acc(0, 1, DRV_UC_HI, {16'h8000, MG[47:32]});
      acc(0, 1, DRV_MC_SET, 32'h8000_0010);
      for (int m = 0; m < 3; m++) begin
         acc(0, 1, DRV_CTRL, 32'(m));
         for (int i = 0; i < 6; i++) begin
            pkt(ADR[i], 14'd100, 4'h0, {HMAP[m][i], 9'h0});
         end
      end
      acc(0, 1, DRV_CTRL, 32'h0);
      // management entry, first without any enable
      cmd(CMD_FILT, MG[31:0]);
      cmd(CMD_FILT + 8'h01, {16'h0, MG[47:32]});
      cmd(CMD_DEC, 32'h1);
      cmd(CMD_MCTL, 32'h1);
      pkt(MG, 14'd100, 4'h0, 10'h000);
      // validity word through the reload port this time
      {nvm_we, nvm_addr, nvm_data} <= {1'b1, CMD_MVAL, 32'h1};
      @(posedge mclk);
      nvm_we <= 1'b0;
      @(posedge mclk);
      pkt(MG, 14'd100, 4'h0, 10'h101);
      pkt(BC, 14'd100, 4'h0, 10'h200);
      pkt(MG, 14'd64, 4'h0, 10'h101);
      pkt(MG, 14'd1522, 4'h0, 10'h101);
      pkt(MG, 14'd63, 4'h0, 10'h000);
      pkt(MG, 14'd1523, 4'h0, 10'h000);
      acc(0, 1, DRV_CTRL, 32'h4);
      pkt(MG, 14'd1523, 4'h0, 10'h101);
      pkt(MG, 14'd100, 4'h4, 10'h000);
      acc(0, 1, DRV_CTRL, 32'h0);
      // copies to host only through the mask
      cmd(CMD_MCTL, 32'h5);
      cmd(CMD_M2H, 32'h1);
      pkt(MG, 14'd100, 4'h0, 10'h301);
      cmd(CMD_M2H, 32'h2);
      pkt(MG, 14'd100, 4'h0, 10'h101);
      cmd(CMD_DEC + 8'h01, 32'h6);
      cmd(CMD_DEC + 8'h02, 32'h1000);
      pkt(BC, 14'd100, 4'h9, 10'h306);
      pkt(BC, 14'd100, 4'hB, 10'h302);
      // everything bit is dropped once decisions are in use
      cmd(CMD_MCTL, 32'h3);
      pkt(UC_X, 14'd100, 4'h0, 10'h000);
      acc(1, 1, {1'b0, MCR_FWRST}, 32'h1);
      pkt(MG, 14'd100, 4'h0, 10'h200);
      cmd(CMD_MCTL, 32'h3);
      pkt(UC_X, 14'd100, 4'h0, 10'h100);
      rd(0, DRV_COUNT, 32'h0011_0009, "counts");
      rd(1, {1'b0, MCR_STATUS}, 32'h0200_0009, "ctl count");
      // second power-on with the other sideband strapped
      rst_dut(1'b1);
      rd(0, DRV_STATUS, 32'h0000_0400, "drv status");
      rd(1, {1'b0, MCR_STATUS}, 32'h0, "ctl status");
      cmd(CMD_MCTL, 32'h3);
      pkt(BC, 14'd100, 4'h0, 10'h200);
      finish_test();
   end
endmodule : test_mgmt_rx_l2_filter
